// *** logic/cpsc_pkg.sv ***
// shared constants and carrier types for the chipset power-state controller
package cpsc_pkg;
    localparam int CPSC_DATA_W = 8;
    localparam int CPSC_CLK_MHZ = 100;
    localparam int CPSC_SLEEP_TO_PRIORITY_BUS_REQUEST_N_NS = 200;
    localparam int CPSC_SLEEP_TO_PRIORITY_BUS_REQUEST_N_CYC = (CPSC_SLEEP_TO_PRIORITY_BUS_REQUEST_N_NS * CPSC_CLK_MHZ + 999) / 1000;
    localparam int CPSC_REFCLK_SETTLE_NS = 1000;
    localparam int CPSC_REFCLK_SETTLE_CYC = (CPSC_REFCLK_SETTLE_NS * CPSC_CLK_MHZ + 999) / 1000;
    localparam int CPSC_THROTTLE_TIMEOUT_US = 100;
    localparam int CPSC_THROTTLE_TIMEOUT_CYC = CPSC_THROTTLE_TIMEOUT_US * CPSC_CLK_MHZ;
    localparam logic [7:0] CPSC_HOT_TRIP_RST = 8'h5a;
    localparam logic [7:0] CPSC_HYSTERESIS_RST = 8'h50;
    localparam logic [3:0] CPSC_VID_NORMAL = 4'h0;
    localparam logic [3:0] CPSC_VID_RS2 = 4'ha;
    localparam logic [2:0] CPSC_PSTATE_MAX = 3'h0;
    localparam logic [2:0] CPSC_PSTATE_MIN = 3'h7;
    localparam logic [2:0] CPSC_PROC_C4 = 3'h4;

    typedef enum logic [1:0] {
        CPSC_MEM_UP = 2'b00,
        CPSC_MEM_PRE_PD = 2'b01,
        CPSC_MEM_ACT_PD = 2'b11,
        CPSC_MEM_SELF_REF = 2'b10
    } cpsc_mem_state_t;

    typedef enum logic [1:0] {
        CPSC_CLK_RUN = 2'b00,
        CPSC_CLK_STOPPED = 2'b01,
        CPSC_CLK_WAKE = 2'b11
    } cpsc_clk_state_t;

    typedef struct packed {
        logic hub_link_l1;
        logic gfx_link_l1;
        logic [2:0] proc_cstate;
        logic wake_request;
    } cpsc_link_status_t;

    typedef struct packed {
        logic render_idle;
        logic basic_video;
    } cpsc_render_status_t;
endpackage

// *** logic/cpsc_power_ctl.sv ***
// power-state controller: memory cke, processor sleep, clock request, render standby and throttling
// Summary of operation
// [RULE_01] memory power-up state keeps clock-enable asserted, memory active
// [RULE_02] precharge power-down drops clock-enable, no self-refresh, all banks closed
// [RULE_03] active power-down drops clock-enable, no self-refresh, some bank open
// [RULE_04] self-refresh drops clock-enable, memory refreshes itself
// [RULE_05] idle power-down picks precharge if all pages closed, else active
// [RULE_06] processor sleep pin is driven only by our sleep output
// [RULE_07] no host-bus transaction until sleep-to-priority-request delay has elapsed
// [RULE_08] drop clock request only with both links in L1 and processor C4 or deeper
// [RULE_09] after clock request drops the reference may stop; internal link clocks stop
// [RULE_10] software must enable link active-state power management for clock request
// [RULE_11] render inactivity or basic video puts render in standby with lower voltage code
// [RULE_12] render core clock gated in every standby level, including level two
// [RULE_13] sensor above hot trip drops render clock to first throttling state
// [RULE_14] after each timeout, resample; still above hysteresis steps down one more
// [RULE_15] no frequency rise until below hysteresis, then return at once to pre-trip state
// [RULE_16] timeout, hot trip and hysteresis are constants loaded at reset
// [RULE_17] reassert clock request, await stable reference before leaving L1 or deep state
`timescale 1ns/1ps
`default_nettype none
module cpsc_power_ctl
    import cpsc_pkg::*;
#(
    parameter int TEMP_W = CPSC_DATA_W,
    parameter int THROTTLE_TIMEOUT_CYC = CPSC_THROTTLE_TIMEOUT_CYC,
    parameter logic [7:0] HOT_TRIP = CPSC_HOT_TRIP_RST,
    parameter logic [7:0] HYSTERESIS = CPSC_HYSTERESIS_RST
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic rank_idle_in,
    input wire logic all_banks_closed_in,
    input wire logic self_refresh_req_in,
    input wire logic sleep_req_in,
    input wire logic host_xact_req_in,
    input wire cpsc_link_status_t link_status_in,
    input wire logic aspm_enable_in,
    input wire logic ref_clock_stable_in,
    input wire cpsc_render_status_t render_status_in,
    input wire logic [TEMP_W-1:0] die_thermal_sensor_in,
    output logic mem_cke_out,
    output logic mem_self_refresh_out,
    output logic proc_sleep_out_n,
    output logic priority_bus_request_n,
    output logic host_xact_grant_out,
    output logic clock_request_n,
    output logic link_clk_gate_out,
    output logic link_exit_ok_out,
    output logic render_clk_gate_out,
    output logic render_standby_level2_out,
    output logic [3:0] voltage_id_code_out,
    output logic [2:0] render_pstate_out
);
    localparam int TMO_W = $clog2(THROTTLE_TIMEOUT_CYC + 1);
    localparam int SLP_W = $clog2(CPSC_SLEEP_TO_PRIORITY_BUS_REQUEST_N_CYC + 1);
    localparam int SET_W = $clog2(CPSC_REFCLK_SETTLE_CYC + 1);

    // pin inputs from other domains pass the three-stage synchroniser
    logic [TEMP_W-1:0] temp_sync;
    logic ref_stable_sync;
    cpsc_sync3 #(.WIDTH(TEMP_W + 1)) u_sync (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .async_in({die_thermal_sensor_in, ref_clock_stable_in}),
        .sync_out({temp_sync, ref_stable_sync})
    );

    // ---------------- memory clock-enable states ----------------
    cpsc_mem_state_t mem_state;
    cpsc_mem_state_t next_mem_state;

    always_comb begin
        next_mem_state = CPSC_MEM_UP;
        if (self_refresh_req_in) begin
            next_mem_state = CPSC_MEM_SELF_REF; // see [RULE_04]
        end else if (rank_idle_in) begin
            // bank state is sampled at the moment of power-down
            if (all_banks_closed_in) begin
                next_mem_state = CPSC_MEM_PRE_PD; // see [RULE_05]
            end else begin
                next_mem_state = CPSC_MEM_ACT_PD; // see [RULE_05]
            end
        end
        unique case (mem_state)
            CPSC_MEM_PRE_PD: begin
                // an opened bank leaves precharge power-down via power-up
                if (next_mem_state == CPSC_MEM_ACT_PD) begin
                    next_mem_state = CPSC_MEM_UP;
                end
            end
            CPSC_MEM_ACT_PD: begin
                if (next_mem_state == CPSC_MEM_PRE_PD) begin
                    next_mem_state = CPSC_MEM_ACT_PD;
                end
            end
            CPSC_MEM_UP, CPSC_MEM_SELF_REF: begin
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mem_state <= CPSC_MEM_UP;
            mem_cke_out <= 1'b1;
            mem_self_refresh_out <= 1'b0;
        end else begin
            mem_state <= next_mem_state;
            // see [RULE_01] cke high only in power-up; see [RULE_02] [RULE_03] [RULE_04]
            mem_cke_out <= (next_mem_state == CPSC_MEM_UP);
            mem_self_refresh_out <= (next_mem_state == CPSC_MEM_SELF_REF);
        end
    end

    // ---------------- processor sleep and host-bus gating ----------------
    logic [SLP_W-1:0] slp_cnt;
    logic slp_ready;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            proc_sleep_out_n <= 1'b1;
            slp_cnt <= SLP_W'(CPSC_SLEEP_TO_PRIORITY_BUS_REQUEST_N_CYC);
            slp_ready <= 1'b1;
        end else begin
            // sole driver of the processor sleep pin; see [RULE_06]
            proc_sleep_out_n <= !sleep_req_in;
            if (sleep_req_in) begin
                slp_cnt <= '0;
                slp_ready <= 1'b0;
            end else if (slp_cnt < SLP_W'(CPSC_SLEEP_TO_PRIORITY_BUS_REQUEST_N_CYC)) begin
                slp_cnt <= slp_cnt + SLP_W'(1);
                slp_ready <= (slp_cnt + SLP_W'(1)) == SLP_W'(CPSC_SLEEP_TO_PRIORITY_BUS_REQUEST_N_CYC); // see [RULE_07]
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            priority_bus_request_n <= 1'b1;
            host_xact_grant_out <= 1'b0;
        end else begin
            // request and grant held off until the sleep exit delay is met; see [RULE_07]
            priority_bus_request_n <= !(host_xact_req_in && slp_ready && !sleep_req_in);
            host_xact_grant_out <= host_xact_req_in && slp_ready && !sleep_req_in;
        end
    end

    // ---------------- reference clock request ----------------
    cpsc_clk_state_t clk_state;
    logic [SET_W-1:0] settle_cnt;
    logic deep_idle;
    // without active-state power management the request is never dropped; see [RULE_10]
    assign deep_idle = aspm_enable_in && link_status_in.hub_link_l1 && link_status_in.gfx_link_l1
        && (link_status_in.proc_cstate >= CPSC_PROC_C4) && !link_status_in.wake_request;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            clk_state <= CPSC_CLK_RUN;
            settle_cnt <= '0;
            clock_request_n <= 1'b0;
            link_clk_gate_out <= 1'b0;
            link_exit_ok_out <= 1'b1;
        end else begin
            unique case (clk_state)
                CPSC_CLK_RUN: begin
                    if (deep_idle) begin
                        clk_state <= CPSC_CLK_STOPPED;
                        clock_request_n <= 1'b1; // see [RULE_08]
                        link_clk_gate_out <= 1'b1; // see [RULE_09]
                        link_exit_ok_out <= 1'b0;
                    end
                end
                CPSC_CLK_STOPPED: begin
                    if (!deep_idle) begin
                        clk_state <= CPSC_CLK_WAKE;
                        clock_request_n <= 1'b0; // see [RULE_17]
                        settle_cnt <= '0;
                    end
                end
                CPSC_CLK_WAKE: begin
                    // wait for a settled reference before links or processor may exit
                    if (!ref_stable_sync) begin
                        settle_cnt <= '0;
                    end else if (settle_cnt < SET_W'(CPSC_REFCLK_SETTLE_CYC)) begin
                        settle_cnt <= settle_cnt + SET_W'(1);
                    end else begin
                        clk_state <= CPSC_CLK_RUN;
                        link_clk_gate_out <= 1'b0;
                        link_exit_ok_out <= 1'b1; // see [RULE_17]
                    end
                end
                default: begin
                    clk_state <= CPSC_CLK_RUN;
                    clock_request_n <= 1'b0;
                end
            endcase
        end
    end

    // ---------------- render standby ----------------
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            render_standby_level2_out <= 1'b0;
            render_clk_gate_out <= 1'b0;
            voltage_id_code_out <= CPSC_VID_NORMAL;
        end else begin
            render_standby_level2_out <= render_status_in.render_idle || render_status_in.basic_video;
            // clock gated whenever any standby level is held; see [RULE_12]
            render_clk_gate_out <= render_status_in.render_idle || render_status_in.basic_video;
            // lower voltage code to the render regulator; see [RULE_11]
            voltage_id_code_out <= (render_status_in.render_idle || render_status_in.basic_video)
                ? CPSC_VID_RS2 : CPSC_VID_NORMAL;
        end
    end

    // ---------------- render thermal throttling ----------------
    // thresholds are fixed at reset, so software cannot race the trip logic; see [RULE_16]
    logic [TEMP_W-1:0] hot_trip;
    logic [TEMP_W-1:0] hyst;
    logic [TMO_W-1:0] tmo_cnt;
    logic throttling;
    logic [2:0] pre_trip_pstate;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hot_trip <= TEMP_W'(HOT_TRIP);
            hyst <= TEMP_W'(HYSTERESIS);
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            throttling <= 1'b0;
            tmo_cnt <= '0;
            render_pstate_out <= CPSC_PSTATE_MAX;
            pre_trip_pstate <= CPSC_PSTATE_MAX;
        end else if (!throttling) begin
            if (temp_sync > hot_trip) begin
                throttling <= 1'b1;
                tmo_cnt <= '0;
                pre_trip_pstate <= render_pstate_out;
                render_pstate_out <= CPSC_PSTATE_MAX + 3'h1; // see [RULE_13]
            end
        end else if (temp_sync < hyst) begin
            throttling <= 1'b0;
            render_pstate_out <= pre_trip_pstate; // see [RULE_15]
        end else if (tmo_cnt == TMO_W'(THROTTLE_TIMEOUT_CYC - 1)) begin
            tmo_cnt <= '0;
            // still hot after the timeout: one more step down; see [RULE_14]
            if (temp_sync > hyst && render_pstate_out != CPSC_PSTATE_MIN) begin
                render_pstate_out <= render_pstate_out + 3'h1;
            end
        end else begin
            tmo_cnt <= tmo_cnt + TMO_W'(1);
        end
    end

    // ---------------- assertions ----------------
    sequence s_sleep_release;
        $rose(proc_sleep_out_n);
    endsequence

    a_cke_power_up: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (mem_state == CPSC_MEM_UP) |-> mem_cke_out) // see [RULE_01]
        else $error("cke low in power-up state");
    a_cke_low_pd: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (mem_state != CPSC_MEM_UP) |-> !mem_cke_out) // see [RULE_02]
        else $error("cke high in power-down state");
    a_pd_choice: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (rank_idle_in && !self_refresh_req_in && all_banks_closed_in && mem_state == CPSC_MEM_UP)
        |=> mem_state == CPSC_MEM_PRE_PD) // see [RULE_05]
        else $error("wrong power-down kind chosen");
    a_self_ref: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        self_refresh_req_in |=> (mem_self_refresh_out && !mem_cke_out)) // see [RULE_04]
        else $error("self-refresh not entered");
    a_sleep_follow: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        sleep_req_in |=> !proc_sleep_out_n) // see [RULE_06]
        else $error("sleep output not asserted");
    a_bus_hold_off: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        s_sleep_release |-> !host_xact_grant_out [*8] ##1 !host_xact_grant_out [*8]
        ##1 !host_xact_grant_out [*3]) // see [RULE_07]
        else $error("host transaction too soon after sleep exit");
    a_clock_request_n_drop: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        $rose(clock_request_n) |-> $past(deep_idle)) // see [RULE_08]
        else $error("clock request dropped without deep idle");
    a_exit_after_req: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        $rose(link_exit_ok_out) |-> !clock_request_n && $past(ref_stable_sync)) // see [RULE_17]
        else $error("exit allowed before reference stable");
    a_standby_vid: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        render_standby_level2_out |-> (render_clk_gate_out && voltage_id_code_out == CPSC_VID_RS2)) // see [RULE_12]
        else $error("standby without gated clock or low code");
    a_trip_first: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (!throttling && temp_sync > hot_trip) |=> render_pstate_out == 3'h1) // see [RULE_13]
        else $error("trip did not drop to first state");
    a_no_rise_hot: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (throttling && temp_sync >= hyst) |=> render_pstate_out >= $past(render_pstate_out)) // see [RULE_15]
        else $error("frequency raised while above hysteresis");
endmodule
`default_nettype wire

// *** logic/cpsc_sync3.sv ***
// three-stage synchroniser for inputs from outside the core clock domain
`timescale 1ns/1ps
`default_nettype none
module cpsc_sync3 #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            // a change counts only once the second and third stage agree
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2[i] == stage3[i]) begin
                    sync_out[i] <= stage3[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/cpsc_partner.sv ***
// far-side model: reference clock generator and the processor sleep pin
`timescale 1ns/1ps
`default_nettype none
module cpsc_partner (
    input wire logic core_clk_in,
    input wire logic slow_in,
    input wire logic clock_request_n,
    input wire logic proc_sleep_out_n,
    output logic ref_clock_stable_out = 1'b1,
    output logic proc_sleep_in_n
);
    int cnt = 0;
    int lim;
    // the processor pin has one driver only, our sleep output
    assign proc_sleep_in_n = proc_sleep_out_n;
    // slow settle exposes any exit taken before the reference is good
    assign lim = clock_request_n ? 3 : (slow_in ? 30 : 2);
    // reference gated only after the request is dropped
    always @(posedge core_clk_in) begin
        if (ref_clock_stable_out === clock_request_n) begin
            cnt <= cnt + 1;
            if (cnt >= lim) begin
                ref_clock_stable_out <= #1 ~ref_clock_stable_out;
                cnt <= 0;
            end
        end else begin
            cnt <= 0;
        end
    end
endmodule
`default_nettype wire

// *** tb/cpsc_power_ctl_tb_top.sv ***
// self-checking bench for the power-state controller
`timescale 1ns/1ps
`default_nettype none
module cpsc_power_ctl_tb_top;
    import cpsc_pkg::*;
    localparam int TMO = 16;
    localparam logic [7:0] TRIP = 8'h60;
    localparam logic [7:0] HYST = 8'h48;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic rank_idle = 1'b0;
    logic closed = 1'b0;
    logic sr_req = 1'b0;
    logic sleep_req = 1'b0;
    logic xact_req = 1'b0;
    logic aspm = 1'b0;
    logic slow = 1'b0;
    cpsc_link_status_t link = '0;
    cpsc_render_status_t rend = '0;
    logic [7:0] temp = 8'h20;
    logic cke, self_ref, sleep_n, priority_bus_request_n_n, grant, clock_request_n_n, link_gate, exit_ok, r_gate, r_lvl2, ref_ok, sleep_in_n;
    logic [3:0] voltage_id_code;
    logic [2:0] pst;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;
    int i;
    always #5 core_clk = ~core_clk;
    // short timeout keeps throttle stepping visible in a brief run
    cpsc_power_ctl #(.THROTTLE_TIMEOUT_CYC(TMO), .HOT_TRIP(TRIP), .HYSTERESIS(HYST)) cpsc_power_ctl_i (
        .core_clk_in(core_clk), .rst_n_in(rst_n), .rank_idle_in(rank_idle), .all_banks_closed_in(closed),
        .self_refresh_req_in(sr_req), .sleep_req_in(sleep_req), .host_xact_req_in(xact_req),
        .link_status_in(link), .aspm_enable_in(aspm), .ref_clock_stable_in(ref_ok), .render_status_in(rend),
        .die_thermal_sensor_in(temp), .mem_cke_out(cke), .mem_self_refresh_out(self_ref),
        .proc_sleep_out_n(sleep_n), .priority_bus_request_n(priority_bus_request_n_n), .host_xact_grant_out(grant),
        .clock_request_n(clock_request_n_n), .link_clk_gate_out(link_gate), .link_exit_ok_out(exit_ok),
        .render_clk_gate_out(r_gate), .render_standby_level2_out(r_lvl2), .voltage_id_code_out(voltage_id_code),
        .render_pstate_out(pst));
    cpsc_partner cpsc_partner_i (.core_clk_in(core_clk), .slow_in(slow), .clock_request_n(clock_request_n_n),
        .proc_sleep_out_n(sleep_n), .ref_clock_stable_out(ref_ok), .proc_sleep_in_n(sleep_in_n));
    task cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task chk_bit(input logic got, input logic exp, input string what);
        check_count = check_count + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask
    task chk_val(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count = check_count + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task wait_pst(input logic [2:0] exp, input int max);
        int k;
        for (k = 0; k < max && pst !== exp; k++) cyc(1);
        chk_val({5'h0, pst}, {5'h0, exp}, "pstate");
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task t_reset;
        chk_bit(cke, 1'b1, "cke in reset");
        chk_bit(sleep_n, 1'b1, "sleep in reset");
        chk_bit(clock_request_n_n, 1'b0, "clock request in reset");
        chk_val({4'h0, voltage_id_code}, {4'h0, CPSC_VID_NORMAL}, "vid in reset");
        chk_val({5'h0, pst}, {5'h0, CPSC_PSTATE_MAX}, "pstate in reset");
        $display("test reset done");
    endtask
    task t_memory;
        rank_idle = 1'b1;
        closed = 1'b1;
        cyc(2);
        chk_bit(cke, 1'b0, "precharge pd cke");
        chk_bit(self_ref, 1'b0, "precharge pd refresh");
        rank_idle = 1'b0;
        cyc(2);
        chk_bit(cke, 1'b1, "power-up cke");
        closed = 1'b0;
        rank_idle = 1'b1;
        cyc(2);
        chk_bit(cke, 1'b0, "active pd cke");
        chk_bit(self_ref, 1'b0, "active pd refresh");
        sr_req = 1'b1;
        cyc(2);
        chk_bit(cke, 1'b0, "self-refresh cke");
        chk_bit(self_ref, 1'b1, "self-refresh flag");
        sr_req = 1'b0;
        rank_idle = 1'b0;
        cyc(2);
        chk_bit(cke, 1'b1, "back to power-up");
        $display("test memory done");
    endtask
    task t_sleep;
        sleep_req = 1'b1;
        cyc(2);
        chk_bit(sleep_in_n, 1'b0, "processor pin asleep");
        xact_req = 1'b1;
        cyc(2);
        sleep_req = 1'b0;
        cyc(2);
        chk_bit(sleep_in_n, 1'b1, "processor pin awake");
        // all but the first cycle of the exit delay is watched, up to the edge before the grant may show
        for (i = 0; i < CPSC_SLEEP_TO_PRIORITY_BUS_REQUEST_N_CYC - 1; i++) begin
            chk_bit(grant | ~priority_bus_request_n_n, 1'b0, "bus held off");
            cyc(1);
        end
        for (i = 0; i < 12 && grant !== 1'b1; i++) cyc(1);
        chk_bit(grant, 1'b1, "grant after delay");
        chk_bit(priority_bus_request_n_n, 1'b0, "priority request");
        xact_req = 1'b0;
        cyc(2);
        $display("test sleep done");
    endtask
    task t_clock_request_n(input logic slow_mode, input logic [2:0] cs, input int lo);
        slow = slow_mode;
        link.hub_link_l1 = 1'b1;
        link.gfx_link_l1 = 1'b1;
        link.proc_cstate = cs;
        cyc(3);
        chk_bit(clock_request_n_n, 1'b0, "no drop without aspm");
        aspm = 1'b1;
        link.proc_cstate = 3'h3;
        cyc(3);
        chk_bit(clock_request_n_n, 1'b0, "no drop at c3");
        link.proc_cstate = cs;
        cyc(2);
        chk_bit(clock_request_n_n, 1'b1, "request dropped");
        chk_bit(link_gate, 1'b1, "link clocks stopped");
        chk_bit(exit_ok, 1'b0, "exit blocked");
        cyc(10);
        link.wake_request = 1'b1;
        cyc(2);
        chk_bit(clock_request_n_n, 1'b0, "request reasserted");
        for (i = 0; i < lo; i++) begin
            chk_bit(exit_ok, 1'b0, "exit before settle");
            cyc(1);
        end
        for (i = 0; i < 80 && exit_ok !== 1'b1; i++) cyc(1);
        chk_bit(exit_ok, 1'b1, "exit after settle");
        chk_bit(link_gate, 1'b0, "link clocks running");
        link = '0;
        aspm = 1'b0;
        cyc(2);
        $display("test clock request done");
    endtask
    task t_render;
        rend.render_idle = 1'b1;
        cyc(2);
        chk_val({4'h0, voltage_id_code}, {4'h0, CPSC_VID_RS2}, "idle vid");
        chk_bit(r_gate & r_lvl2, 1'b1, "idle standby gate");
        rend = '0;
        cyc(2);
        chk_val({4'h0, voltage_id_code}, {4'h0, CPSC_VID_NORMAL}, "active vid");
        chk_bit(r_gate | r_lvl2, 1'b0, "active clock");
        rend.basic_video = 1'b1;
        cyc(2);
        chk_val({4'h0, voltage_id_code}, {4'h0, CPSC_VID_RS2}, "video vid");
        chk_bit(r_gate & r_lvl2, 1'b1, "video standby gate");
        rend = '0;
        cyc(2);
        $display("test render done");
    endtask
    task t_throttle;
        temp = TRIP;
        cyc(30);
        chk_val({5'h0, pst}, 8'h00, "no trip at threshold");
        temp = TRIP + 8'h01;
        wait_pst(3'h1, 8);
        for (i = 0; i < TMO - 6; i++) begin
            cyc(1);
            chk_val({5'h0, pst}, 8'h01, "first state held");
        end
        wait_pst(3'h2, 12);
        temp = HYST;
        cyc(40);
        chk_val({5'h0, pst}, 8'h02, "held at hysteresis");
        temp = HYST - 8'h01;
        wait_pst(CPSC_PSTATE_MAX, 8);
        $display("test throttle done");
    endtask
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %0t timeout", $time);
            stop_test;
        end
    end
    initial begin
        cyc(1);
        t_reset;
        cyc(1);
        rst_n = 1'b1;
        cyc(4);
        t_memory;
        t_sleep;
        t_clock_request_n(1'b0, CPSC_PROC_C4, 95);
        t_clock_request_n(1'b1, 3'h6, 120);
        t_render;
        t_throttle;
        stop_test;
    end
endmodule
`default_nettype wire
